// >>> logic/sfl_cfg_top.sv
/*
 * Serial configuration logic for the fractional synthesizer: three-wire shift
 * port, two latched config words, lock pin routing, auxiliary pins and
 * power-down timing. Assumes serial pins and divider edges are asynchronous
 * and slower than clk (bench serial clock 64 ns period).
 */
// Summary of operation
// RULE1: Address 00 at latch strobe rise copies data into fractional_lock_config.
// RULE2: Address 01 at latch strobe rise copies data into output_powerdown_config.
// RULE3: Bit 20 of first word selects modulus sixteen when one, fifteen when zero.
// RULE4: Lock pin: 000 analog, 010 digital lock, 110 feedback, 111 reference divider.
// RULE5: Host never programs lock pin codes 001, 011, 100 or 101; the bench writes all eight codes.
// RULE6: Locked with lock-detect selected, lock pin high apart from brief low pulses.
// RULE7: Lock declared after five consecutive reference cycles under about 15 ns error.
// RULE8: Once locked window widens to about 30 ns; exceeding it leaves lock.
// RULE9: Unlocked loop drives digital lock-detect output low.
// RULE10: Host writes zero to unused bits; device ignores them.
// RULE11: Second word holds only the four aux bits and power-down timing bit.
// RULE12: Timing bit one waits for pump pulse end; zero powers down immediately.
// RULE13: General-purpose mode drives aux pins from bits 15 and 16.
// RULE14: Test bit 17 puts both aux pins in test mode, overriding others.
// RULE15: Bit 18 selects quick-acquire when high, general-purpose when low.
// RULE16: Quick-acquire drives aux_pin0 low while pump boost high, else released.
// RULE17: Quick-acquire ignores level bits and releases aux_pin1.
// RULE18: Data arrives MSB first; one bit shifts in per serial clock rise.
// RULE19: Shift bits 1:0 are address, bits 23:2 are data 21:0.
module sfl_cfg_top import sfl_pkg::*; #(
	parameter int unsigned LOCK_CYCLES = SFL_LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic latch_strobe,
	input wire logic ref_div_edge,
	input wire logic fb_div_edge,
	input wire logic pump_gain_boost,
	input wire logic pump_pulse_active,
	input wire logic powerdown_req,
	input wire logic analog_lock_n,
	input wire logic [1:0] aux_test_level,
	output logic lock_pin_o,
	output logic lock_pin_oe,
	output logic aux_pin0_o,
	output logic aux_pin0_oe,
	output logic aux_pin1_o,
	output logic aux_pin1_oe,
	output logic modulus_sixteen_select,
	output logic [2:0] lock_pin_function,
	output logic powerdown_timing_select,
	output logic powered_down
);
	// Synchronised pin levels and their rising edges.
	logic sclk_rise;
	logic sdat_lvl;
	logic le_rise;
	logic ref_lvl;
	logic ref_rise;
	logic fb_lvl;
	logic fb_rise;
	logic boost_lvl;
	logic pulse_lvl;
	logic pd_lvl;
	logic alock_lvl;
	logic tst0_lvl;
	logic tst1_lvl;

	// Filter verdict, shift path, latched words and decoded aux modes.
	logic dig_locked;
	logic [SFL_SHIFT_W-1:0] shift_r;
	logic [SFL_DATA_W-1:0] flk_cfg_r;
	logic [SFL_DATA_W-1:0] opd_cfg_r;
	logic [3:0] aux_ctrl;
	logic aux_test;
	logic aux_qacq;
	logic pd_r;

	// Serial port pins cross into clk through two flops each. Data and clock
	// share the same delay, so a sampled bit stays aligned with its clock edge.
	sfl_sync u_sync_sclk (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(ser_clk),
		.level(),
		.rise(sclk_rise)
	);
	sfl_sync u_sync_sdat (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(ser_data),
		.level(sdat_lvl),
		.rise()
	);
	sfl_sync u_sync_le (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(latch_strobe),
		.level(),
		.rise(le_rise)
	);

	// Divider outputs; the lock filter uses their edges, the lock pin their levels.
	sfl_sync u_sync_ref (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(ref_div_edge),
		.level(ref_lvl),
		.rise(ref_rise)
	);
	sfl_sync u_sync_fb (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(fb_div_edge),
		.level(fb_lvl),
		.rise(fb_rise)
	);

	// Loop status and test levels, read only as levels.
	sfl_sync u_sync_boost (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(pump_gain_boost),
		.level(boost_lvl),
		.rise()
	);
	sfl_sync u_sync_pulse (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(pump_pulse_active),
		.level(pulse_lvl),
		.rise()
	);
	sfl_sync u_sync_pd (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(powerdown_req),
		.level(pd_lvl),
		.rise()
	);
	sfl_sync u_sync_alock (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(analog_lock_n),
		.level(alock_lvl),
		.rise()
	);
	sfl_sync u_sync_tst0 (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(aux_test_level[0]),
		.level(tst0_lvl),
		.rise()
	);
	sfl_sync u_sync_tst1 (
		.clk(clk),
		.rst_n(rst_n),
		.async_in(aux_test_level[1]),
		.level(tst1_lvl),
		.rise()
	);

	// Shift register; data is synchronised alongside clock so the sample is aligned.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_r <= 24'h000000;
		end else if (sclk_rise) begin
			shift_r <= {shift_r[SFL_SHIFT_W-2:0], sdat_lvl}; // RULE18
		end
	end

	// Address decode and data extraction are shared by both word loads.
	function automatic logic addr_is(
		input logic [SFL_SHIFT_W-1:0] word,
		input logic [1:0] code
	);
		return word[1:0] == code; // RULE19
	endfunction

	function automatic logic [SFL_DATA_W-1:0] data_of(input logic [SFL_SHIFT_W-1:0] word);
		return word[SFL_SHIFT_W-1:2]; // RULE19
	endfunction

	// First word loads only on its own address at the latch strobe rise.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flk_cfg_r <= SFL_CFG_RESET;
		end else if (le_rise && addr_is(shift_r, SFL_ADDR_FLK)) begin
			flk_cfg_r <= data_of(shift_r); // RULE1
		end
	end

	// Second word; addresses 10 and 11 belong to other registers and load nothing here.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opd_cfg_r <= SFL_CFG_RESET;
		end else if (le_rise && addr_is(shift_r, SFL_ADDR_OPD)) begin
			opd_cfg_r <= data_of(shift_r); // RULE2
		end
	end

	// First word: only the modulus bit and the lock pin code are used; the
	// remaining stored bits are ignored.
	assign modulus_sixteen_select = flk_cfg_r[SFL_MOD16_BIT]; // RULE3
	assign lock_pin_function = flk_cfg_r[SFL_LPF_LSB+2:SFL_LPF_LSB]; // RULE4

	// Second word: four aux bits and the power-down timing bit, nothing else.
	assign aux_ctrl = opd_cfg_r[SFL_QACQ_BIT:SFL_AUX0_BIT]; // RULE11
	assign powerdown_timing_select = opd_cfg_r[SFL_PDT_BIT]; // RULE11
	assign aux_test = aux_ctrl[SFL_TEST_BIT-SFL_AUX0_BIT]; // RULE14
	assign aux_qacq = aux_ctrl[SFL_QACQ_BIT-SFL_AUX0_BIT]; // RULE15

	// Digital lock filter is cleared while another pin function is chosen.
	sfl_lock_filter #(.LOCK_CYCLES(LOCK_CYCLES)) u_lock (
		.clk(clk),
		.rst_n(rst_n),
		.enable(lock_pin_function == SFL_LPF_DLD),
		.ref_rise(ref_rise),
		.fb_rise(fb_rise),
		.locked(dig_locked)
	);

	// Lock pin routing. Analog mode is open drain: pulled low only when the
	// analog detector reports error; otherwise released to the pull-up.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_pin_o <= 1'b0;
			lock_pin_oe <= 1'b0;
		end else begin
			unique case (lock_pin_function) // RULE4
				SFL_LPF_ALD: begin
					lock_pin_o <= 1'b0;
					lock_pin_oe <= ~alock_lvl; // RULE6
				end
				SFL_LPF_DLD: begin
					lock_pin_o <= dig_locked; // RULE9
					lock_pin_oe <= 1'b1;
				end
				SFL_LPF_NDIV: begin
					lock_pin_o <= fb_lvl;
					lock_pin_oe <= 1'b1;
				end
				SFL_LPF_RDIV: begin
					lock_pin_o <= ref_lvl;
					lock_pin_oe <= 1'b1;
				end
				default: begin
					// Disallowed codes leave the pin released. RULE5
					lock_pin_o <= 1'b0;
					lock_pin_oe <= 1'b0;
				end
			endcase
		end
	end

	// Pin 0: test overrides quick-acquire, which overrides the stored level.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aux_pin0_o <= 1'b0;
			aux_pin0_oe <= 1'b0;
		end else if (aux_test) begin
			aux_pin0_o <= tst0_lvl; // RULE14
			aux_pin0_oe <= 1'b1;
		end else if (aux_qacq) begin // RULE15
			aux_pin0_o <= 1'b0;
			aux_pin0_oe <= boost_lvl; // RULE16
		end else begin
			aux_pin0_o <= aux_ctrl[0]; // RULE13
			aux_pin0_oe <= 1'b1;
		end
	end

	// Pin 1 is released in quick-acquire, so its stored level is ignored there.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			aux_pin1_o <= 1'b0;
			aux_pin1_oe <= 1'b0;
		end else if (aux_test) begin
			aux_pin1_o <= tst1_lvl; // RULE14
			aux_pin1_oe <= 1'b1;
		end else if (aux_qacq) begin // RULE15
			aux_pin1_o <= 1'b0;
			aux_pin1_oe <= 1'b0; // RULE17
		end else begin
			aux_pin1_o <= aux_ctrl[SFL_AUX1_BIT-SFL_AUX0_BIT]; // RULE13
			aux_pin1_oe <= 1'b1;
		end
	end

	// Synchronous mode waits for the pump pulse to finish so no half pulse
	// disturbs the loop filter; power-up is always immediate.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pd_r <= 1'b0;
		end else if (!pd_lvl) begin
			pd_r <= 1'b0;
		end else if (!powerdown_timing_select || !pulse_lvl) begin
			pd_r <= 1'b1; // RULE12
		end
	end

	// The power-down state leaves the block straight from its flop.
	assign powered_down = pd_r;
endmodule // sfl_cfg_top

// >>> logic/sfl_lock_filter.sv
/*
 * Digital lock filter: measures the gap between reference and feedback edges.
 * Assumes synchronised one-cycle edge pulses on clk.
 */
module sfl_lock_filter import sfl_pkg::*; #(
	parameter int unsigned LOCK_CYCLES = SFL_LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic ref_rise,
	input wire logic fb_rise,
	output logic locked
);
	logic [7:0] gap_r;
	logic open_r;
	logic [3:0] good_r;
	logic [7:0] win;
	logic pair_done;
	logic pair_bad;
	logic pair_even;

	// The window widens once lock is declared, giving hysteresis.
	assign win = locked ? 8'(SFL_WIN_HOLD_CYC) : 8'(SFL_WIN_ACQ_CYC); // RULE8
	assign pair_done = open_r & (ref_rise | fb_rise);
	assign pair_bad = open_r & (gap_r >= win);
	// Edges landing in the same cycle form a pair with no measurable error.
	assign pair_even = ~open_r & ref_rise & fb_rise; // RULE7

	// Gap counter runs from the first edge of a pair to the second.
	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			open_r <= 1'b0;
			gap_r <= 8'h00;
		end else if (pair_done || pair_bad) begin
			open_r <= 1'b0;
			gap_r <= 8'h00;
		end else if (ref_rise ^ fb_rise) begin
			open_r <= 1'b1;
			gap_r <= 8'h00;
		end else if (open_r) begin
			gap_r <= gap_r + 8'h01;
		end
	end

	// Count good reference cycles; a bad one drops lock at once.
	always_ff @(posedge clk) begin
		if (!rst_n || !enable) begin
			good_r <= 4'h0;
			locked <= 1'b0;
		end else if (pair_bad) begin
			good_r <= 4'h0;
			locked <= 1'b0; // RULE8
		end else if ((pair_done || pair_even) && !locked) begin
			if (good_r == 4'(LOCK_CYCLES - 1)) begin
				locked <= 1'b1; // RULE7
			end else begin
				good_r <= good_r + 4'h1; // RULE7
			end
		end
	end
endmodule // sfl_lock_filter

// >>> logic/sfl_pkg.sv
/*
 * Shared constants for the synthesizer configuration block: serial word
 * layout, address codes, field positions, lock pin codes and lock-filter timing.
 * Assumes a single 125 MHz system clock.
 */
package sfl_pkg;
	localparam int unsigned SFL_CLK_MHZ = 125;
	localparam int unsigned SFL_SHIFT_W = 24;
	localparam int unsigned SFL_DATA_W = 22;
	localparam logic [1:0] SFL_ADDR_FLK = 2'h0;
	localparam logic [1:0] SFL_ADDR_OPD = 2'h1;
	localparam logic [21:0] SFL_CFG_RESET = 22'h000000;
	// Field positions inside the 22-bit data word.
	localparam int unsigned SFL_MOD16_BIT = 20;
	localparam int unsigned SFL_LPF_LSB = 17;
	localparam int unsigned SFL_AUX0_BIT = 15;
	localparam int unsigned SFL_AUX1_BIT = 16;
	localparam int unsigned SFL_TEST_BIT = 17;
	localparam int unsigned SFL_QACQ_BIT = 18;
	localparam int unsigned SFL_PDT_BIT = 19;
	// Lock pin function codes.
	localparam logic [2:0] SFL_LPF_ALD = 3'h0;
	localparam logic [2:0] SFL_LPF_DLD = 3'h2;
	localparam logic [2:0] SFL_LPF_NDIV = 3'h6;
	localparam logic [2:0] SFL_LPF_RDIV = 3'h7;
	// Lock filter windows in ns and their cycle counts.
	localparam int unsigned SFL_WIN_ACQ_NS = 15;
	localparam int unsigned SFL_WIN_HOLD_NS = 30;
	localparam int unsigned SFL_WIN_ACQ_CYC = (SFL_WIN_ACQ_NS * SFL_CLK_MHZ) / 1000;
	localparam int unsigned SFL_WIN_HOLD_CYC = (SFL_WIN_HOLD_NS * SFL_CLK_MHZ) / 1000;
	localparam int unsigned SFL_LOCK_CYCLES = 5;
endpackage

// >>> logic/sfl_sync.sv
/*
 * Two-flop synchroniser with rising edge output taken after the second flop.
 * Assumes the input is asynchronous to clk.
 */
module sfl_sync import sfl_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic level,
	output logic rise
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	// Only the second flop and the edge register look past the first stage.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign level = sync_r;
	assign rise = sync_r & ~prev_r;
endmodule // sfl_sync

// >>> verif/sfl_cfg_monitor.sv
/* Pin checker for the synthesizer configuration block.
 * Bound to sfl_cfg_top and sees only its ports. */
module sfl_cfg_monitor import sfl_pkg::*; #(
	parameter int unsigned LOCK_CYCLES = SFL_LOCK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ref_div_edge,
	input wire logic fb_div_edge,
	input wire logic pump_pulse_active,
	input wire logic powerdown_req,
	input wire logic analog_lock_n,
	input wire logic lock_pin_o,
	input wire logic lock_pin_oe,
	input wire logic [2:0] lock_pin_function,
	input wire logic powerdown_timing_select,
	input wire logic powered_down
);
	// Every check runs on the system clock and sleeps in reset.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	ref_route_a: assert property (
		(lock_pin_function == SFL_LPF_RDIV)[*6] ##0 $rose(ref_div_edge) |-> ##[1:6] lock_pin_o)
		else $error("lock pin missed a reference edge");
	fb_route_a: assert property (
		(lock_pin_function == SFL_LPF_NDIV)[*6] ##0 $fell(fb_div_edge) |-> ##[1:6] !lock_pin_o)
		else $error("lock pin missed a feedback edge");
	bad_code_a: assert property (
		(lock_pin_function inside {3'h1, 3'h3, 3'h4, 3'h5})[*3] |-> !lock_pin_oe)
		else $error("lock pin driven under a disallowed code");
	ald_pull_a: assert property (
		(lock_pin_function == SFL_LPF_ALD && !analog_lock_n)[*5] |-> lock_pin_oe && !lock_pin_o)
		else $error("open drain lock pin not pulled low");
	dld_low_a: assert property (
		lock_pin_function != SFL_LPF_DLD ##1 (lock_pin_function == SFL_LPF_DLD)[*8] |-> !lock_pin_o)
		else $error("digital lock high before any lock");
	pd_async_a: assert property (
		(!powerdown_timing_select && powerdown_req)[*5] |-> powered_down)
		else $error("immediate power down late");
	pd_sync_a: assert property (
		(powerdown_timing_select && pump_pulse_active && !powered_down)[*5] |=> !powered_down)
		else $error("power down cut a pump pulse");
	pd_wake_a: assert property (
		(!powerdown_req)[*5] |-> !powered_down)
		else $error("power down without request");
	// Main scenarios reached.
	cover property (powered_down);
	cover property (lock_pin_function == SFL_LPF_DLD && $rose(lock_pin_o));
	cover property (lock_pin_function == SFL_LPF_RDIV && lock_pin_o);
endmodule // sfl_cfg_monitor

bind sfl_cfg_top sfl_cfg_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) u_sfl_cfg_monitor (.clk, .rst_n,
	.ref_div_edge, .fb_div_edge, .pump_pulse_active, .powerdown_req, .analog_lock_n,
	.lock_pin_o, .lock_pin_oe, .lock_pin_function, .powerdown_timing_select, .powered_down);

// >>> verif/sfl_host_model.sv
/* Host controller model for the three-wire serial port.
 * Assumes callers run on the falling edge of clk. */
module sfl_host_model (
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic latch_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	// The serial clock rests low between frames.
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b1;
		latch_strobe = 1'b0;
	end
	// Sends one word; half sets each level in clk cycles, at least three.
	task automatic send(input logic [23:0] w, input int half);
		for (int i = 23; i >= 0; i--) begin
			ser_data = w[i];
			repeat (half) @(negedge clk);
			ser_clk = 1'b1;
			repeat (half) @(negedge clk);
			ser_clk = 1'b0;
		end
		// Idle data shows the inverse so a stale bit cannot pass.
		ser_data = ~w[0];
		latch_strobe = 1'b1;
		repeat (half) @(negedge clk);
		latch_strobe = 1'b0;
	endtask
endmodule // sfl_host_model

// >>> verif/synth_fractional_lock_output_cfg_tb_top.sv
/* Self-checking bench for the synthesizer configuration block.
 * Assumes the host model and the bound pin checker. */
module synth_fractional_lock_output_cfg_tb_top import sfl_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, ser_clk, ser_data, latch_strobe, ref_div_edge, fb_div_edge;
	logic pump_gain_boost, pump_pulse_active, powerdown_req, analog_lock_n;
	logic [1:0] aux_test_level;
	logic lock_pin_o, lock_pin_oe, aux_pin0_o, aux_pin0_oe, aux_pin1_o, aux_pin1_oe;
	logic modulus_sixteen_select, powerdown_timing_select, powered_down;
	logic [2:0] lock_pin_function;
	int error_cnt = 0;
	int check_count = 0;
	sfl_host_model u_sfl_host_model (.clk, .ser_clk, .ser_data, .latch_strobe);
	sfl_cfg_top #(.LOCK_CYCLES(5)) u_sfl_cfg_top (.clk, .rst_n, .ser_clk, .ser_data,
		.latch_strobe, .ref_div_edge, .fb_div_edge, .pump_gain_boost, .pump_pulse_active,
		.powerdown_req, .analog_lock_n, .aux_test_level, .lock_pin_o, .lock_pin_oe,
		.aux_pin0_o, .aux_pin0_oe, .aux_pin1_o, .aux_pin1_oe, .modulus_sixteen_select,
		.lock_pin_function, .powerdown_timing_select, .powered_down);
	// Clock at 125 MHz.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	// Writes one word; the wait covers synchroniser and pin latency.
	task automatic wr(input logic [1:0] a, input logic [21:0] d);
		u_sfl_host_model.send({d, a}, 4);
		wt(10);
	endtask
	// Divider edges; skew delays the feedback rise by whole clk cycles.
	task automatic pulses(input int n, input int skew);
		repeat (n) begin
			ref_div_edge = 1'b1;
			wt(skew);
			fb_div_edge = 1'b1;
			wt(8);
			ref_div_edge = 1'b0;
			fb_div_edge = 1'b0;
			wt(8);
		end
	endtask
	function automatic logic [7:0] aux4();
		return {4'h0, aux_pin1_oe, aux_pin1_o, aux_pin0_oe, aux_pin0_o};
	endfunction
	function automatic logic [7:0] flk();
		return {4'h0, modulus_sixteen_select, lock_pin_function};
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Guard against a hang.
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
	// Main sequence, inputs changed on the falling edge.
	initial begin
		{rst_n, ref_div_edge, fb_div_edge, pump_gain_boost, pump_pulse_active} = '0;
		{powerdown_req, aux_test_level} = '0;
		analog_lock_n = 1'b1;
		wt(4);
		rst_n = 1'b1;
		wt(4);
		chk(8'h0A, aux4());
		chk(8'h00, flk());
		$display("test reset done");
		wr(2'h0, 22'h1E0000);
		chk(8'h0F, flk());
		wr(2'h2, 22'h000000);
		wr(2'h3, 22'h000000);
		chk(8'h0F, flk());
		pulses(2, 0);
		wr(2'h0, 22'h0C0000);
		chk(8'h06, flk());
		pulses(2, 0);
		for (int c = 0; c < 8; c++) begin
			wr(2'h0, 22'(c) << 17);
			chk(8'(c), 8'(lock_pin_function));
			chk(8'(c inside {2, 6, 7}), 8'(lock_pin_oe));
		end
		wr(2'h0, 22'h000000);
		analog_lock_n = 1'b0;
		wt(6);
		chk(8'h02, {6'h00, lock_pin_oe, lock_pin_o});
		analog_lock_n = 1'b1;
		$display("test lock codes done");
		wr(2'h1, 22'h008000);
		chk(8'h0B, aux4());
		wr(2'h1, 22'h010000);
		chk(8'h0E, aux4());
		pump_gain_boost = 1'b1;
		wr(2'h1, 22'h058000);
		chk(8'h02, {5'h00, aux_pin1_oe, aux_pin0_oe, aux_pin0_o});
		pump_gain_boost = 1'b0;
		wt(6);
		chk(8'h00, {6'h00, aux_pin1_oe, aux_pin0_oe});
		aux_test_level = 2'h2;
		wr(2'h1, 22'h060000);
		chk(8'h0E, aux4());
		$display("test aux pins done");
		wr(2'h1, 22'h000000);
		powerdown_req = 1'b1;
		wt(6);
		chk(8'h01, 8'(powered_down));
		powerdown_req = 1'b0;
		wt(6);
		wr(2'h1, 22'h080000);
		chk(8'h01, 8'(powerdown_timing_select));
		pump_pulse_active = 1'b1;
		powerdown_req = 1'b1;
		wt(8);
		chk(8'h00, 8'(powered_down));
		pump_pulse_active = 1'b0;
		wt(6);
		chk(8'h01, 8'(powered_down));
		powerdown_req = 1'b0;
		$display("test power down done");
		wr(2'h0, 22'h040000);
		pulses(8, 2);
		chk(8'h00, 8'(lock_pin_o));
		pulses(4, 0);
		chk(8'h00, 8'(lock_pin_o));
		pulses(2, 0);
		chk(8'h01, 8'(lock_pin_o));
		pulses(4, 2);
		chk(8'h01, 8'(lock_pin_o));
		pulses(2, 5);
		chk(8'h00, 8'(lock_pin_o));
		$display("test lock filter done");
		complete_run();
	end
endmodule // synth_fractional_lock_output_cfg_tb_top
